// File: logic/nac_consts.svh
// Offsets, field positions and reset values of the accumulator block.
// Assumes inclusion by the package and by the design module only.
`ifndef NAC_CONSTS_SVH
`define NAC_CONSTS_SVH
`define NAC_CTRL_ADDR 12'h000
`define NAC_STAT_ADDR 12'h004
`define NAC_CTRL_RESET 32'h0000_0000
`define NAC_CTRL_WMASK 32'h0000_00FF
`define NAC_CTRL_CLEAR_BIT 8
`define NAC_OFS_NONE 4'h0
`define NAC_OFS_LOW 4'h2
`define NAC_OFS_HIGH 4'h4
`define NAC_OFS_BOTH 4'h8
`define NAC_ACC_RESET 4'h0
`endif

// File: logic/nac_pkg.sv
// Types shared by the accumulator block.
// Assumes nac_consts.svh sits beside it.
`include "nac_consts.svh"
package nac_pkg;
	// Control word as software writes it
	typedef struct packed {
		logic [1:0] offset_sw; // Bit 1 upper switch, bit 0 lower switch
		logic async_mode; // Output source select: 1 takes the adder
		logic subtract; // Count direction select
		logic [3:0] weight_sw; // Weight switches 8,4,2,1
	} nac_ctrl_t;
	// Level words driven toward the converters
	typedef struct packed {
		logic [3:0] primary;
		logic [3:0] shifted;
	} nac_levels_t;
	// Whole state of the block
	typedef struct packed {
		logic [3:0] acc;
		logic carry;
		logic flip;
		nac_ctrl_t ctrl;
		logic clk_d;
		logic xor_d;
		logic dir_d;
		logic rst_d;
		logic [31:0] prdata;
	} nac_state_t;
endpackage

// File: logic/nac_accum.sv
// Four-bit accumulator with rotate path, overflow pulse and two level words.
// Assumes all pins are synchronous to pclk and an APB master on the bus side.
// What this block does
// (RQ1) Addend bits are weight switch OR gate input of the same weight.
// (RQ2) Register takes register plus addend on each accumulate edge.
// (RQ3) Sum above 15 wraps modulo 16.
// (RQ4) Overflow output high for one input clock period after overflow.
// (RQ5) Four gate outputs follow register bits, weights 8,4,2,1.
// (RQ6) Primary level word is the register value.
// (RQ7) Second level word is register value plus switch-selected offset.
// (RQ8) Offset switches: none 0, lower 2, upper 4, both 8.
// (RQ9) Second level word wraps modulo 16.
// (RQ10) Rotate request high in synchronous mode rotates upward on clock edges.
// (RQ11) Output source select picks register or live adder output.
// (RQ12) Asynchronous mode rotates on edges of rotate XOR clock input.
// (RQ13) Direction select chooses add or subtract.
// (RQ14) Addend 8 alternates values; addend 0 holds register.
// (RQ15) A rotate edge replaces the accumulate step on that edge.
// (RQ16) Reset input or button clears register and overflow output to zero.
// (RQ17) Rising edge on direction flip input inverts counting direction.
// (RQ18) Serial fill feeds the bottom bit; unconnected, top bit recirculates.
// (RQ19) Serial mix is XORed into the bit entering the register.
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`include "nac_consts.svh"
module nac_accum (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Gate inputs
	input wire logic [3:0] gate_in,
	input wire logic carry_in,
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic dir_flip_in,
	// Shift register inputs
	input wire logic rotate_req,
	input wire logic fill_in,
	input wire logic fill_present,
	input wire logic mix_in,
	// Outputs
	output logic [3:0] gate_out,
	output logic carry_out,
	output nac_pkg::nac_levels_t levels
);
	// Offset decode, shared by the datapath and its checks
	function automatic logic [3:0] offset_of(input logic [1:0] sw);
		case (sw)
			2'b00: offset_of = `NAC_OFS_NONE;
			2'b01: offset_of = `NAC_OFS_LOW;
			2'b10: offset_of = `NAC_OFS_HIGH;
			default: offset_of = `NAC_OFS_BOTH;
		endcase
	endfunction

	nac_pkg::nac_state_t st;
	nac_pkg::nac_state_t next_st;
	logic [3:0] addend;
	logic subtract_eff;
	logic [4:0] sum_wide;
	logic [3:0] adder_out;
	logic overflow;
	logic clk_rise;
	logic xor_rise;
	logic rotate_edge;
	logic accum_edge;
	logic clear_edge;
	logic bit_entering;
	logic [3:0] shown;
	logic wr_access;
	logic rd_setup;
	logic mapped;
	logic clear_now;

	// Addend from switches and gates; carry input doubles as weight 1
	assign addend = st.ctrl.weight_sw | gate_in | {3'b000, carry_in}; // RQ1
	assign subtract_eff = st.ctrl.subtract ^ st.flip; // RQ13 RQ17

	// Five-bit result: bit 4 is carry on add, borrow on subtract
	assign sum_wide = subtract_eff ? ({1'b0, st.acc} - {1'b0, addend})
		: ({1'b0, st.acc} + {1'b0, addend}); // RQ2 RQ13
	assign adder_out = sum_wide[3:0]; // RQ3
	assign overflow = sum_wide[4]; // RQ4

	// Edge detection on the pins, all sampled against pclk
	assign clk_rise = clock_in & ~st.clk_d;
	assign xor_rise = (clock_in ^ rotate_req) & ~st.xor_d;
	assign clear_edge = reset_in & ~st.rst_d;
	// Any clear this cycle, from the pin edge or the software pulse
	assign clear_now = clear_edge || (wr_access && pwdata[`NAC_CTRL_CLEAR_BIT]);

	// Sync mode rotates on a clock edge with rotate high; async on the XOR edge
	assign rotate_edge = st.ctrl.async_mode ? xor_rise : (clk_rise & rotate_req); // RQ10 RQ12
	assign accum_edge = clk_rise & ~rotate_edge; // RQ15

	// Bit entering the bottom of the shift path
	assign bit_entering = (fill_present ? fill_in : st.acc[3]) ^ mix_in; // RQ18 RQ19

	// APB decode; the slave answers with no wait states
	assign mapped = (paddr == `NAC_CTRL_ADDR) || (paddr == `NAC_STAT_ADDR);
	assign wr_access = psel & penable & pwrite & (paddr == `NAC_CTRL_ADDR);
	assign rd_setup = psel & ~penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = st.prdata;

	// Next-state logic
	always_comb begin
		next_st = st;
		next_st.clk_d = clock_in;
		next_st.xor_d = clock_in ^ rotate_req;
		next_st.dir_d = dir_flip_in;
		next_st.rst_d = reset_in;
		if (dir_flip_in & ~st.dir_d) begin
			next_st.flip = ~st.flip; // RQ17
		end
		if (wr_access) begin
			next_st.ctrl = nac_pkg::nac_ctrl_t'(pwdata[7:0]);
		end
		// Rotate wins over accumulate; carry lasts until the next clock edge
		if (rotate_edge) begin
			next_st.acc = {st.acc[2:0], bit_entering}; // RQ10 RQ12 RQ18
		end else if (accum_edge) begin
			next_st.acc = adder_out; // RQ2 RQ3 RQ14
		end
		if (clk_rise) begin
			next_st.carry = accum_edge & overflow; // RQ4
		end
		// Clear has top priority so a reset pulse at audio rate acts as hard sync
		if (clear_now) begin
			next_st.acc = `NAC_ACC_RESET; // RQ16
			next_st.carry = 1'b0; // RQ16
		end
		// Read data is captured in setup so it is stable through the access
		next_st.prdata = 32'h0000_0000;
		if (rd_setup && paddr == `NAC_CTRL_ADDR) begin
			next_st.prdata = {24'h00_0000, st.ctrl};
		end else if (rd_setup && paddr == `NAC_STAT_ADDR) begin
			next_st.prdata = {18'h0_0000, addend, subtract_eff, st.carry,
				levels.shifted, st.acc};
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Output source: register, or the live adder in async mode
	assign shown = st.ctrl.async_mode ? adder_out : st.acc; // RQ11
	assign levels.primary = shown; // RQ6
	assign levels.shifted = shown + offset_of(st.ctrl.offset_sw); // RQ7 RQ8 RQ9
	assign carry_out = st.carry; // RQ4

	// One gate output per register bit
	for (genvar i = 0; i < 4; i++) begin : g_gate
		assign gate_out[i] = shown[i]; // RQ5
	end

	// Checks
	chk_accum_step: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
		(accum_edge && !clear_edge && !(wr_access && pwdata[`NAC_CTRL_CLEAR_BIT]))
		|=> st.acc == ($past(subtract_eff) ? $past(st.acc) - $past(addend)
			: $past(st.acc) + $past(addend)))
		else $error("accumulate step wrong");
	chk_wrap_add: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
		(accum_edge && !subtract_eff && !clear_edge && st.acc == 4'hE && addend == 4'h4
		&& !wr_access) |=> st.acc == 4'h2)
		else $error("wrap failed");
	chk_carry_pulse: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
		(accum_edge && overflow && !clear_edge && !wr_access) |=> carry_out
		until_with (clk_rise || clear_edge))
		else $error("carry not held for period");
	chk_carry_drop: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
		(clk_rise && !(accum_edge && overflow)) |=> !carry_out)
		else $error("carry stuck");
	chk_level_offset: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
		levels.shifted == 4'(levels.primary + offset_of(st.ctrl.offset_sw)))
		else $error("offset level wrong");
	chk_rotate_sync: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
		(!st.ctrl.async_mode && clk_rise && rotate_req && !clear_edge && !wr_access)
		|=> st.acc == {$past(st.acc[2:0]), $past(bit_entering)})
		else $error("sync rotate wrong");
	chk_rotate_async: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
		(st.ctrl.async_mode && xor_rise && !clear_edge && !wr_access)
		|=> st.acc[0] == $past(bit_entering))
		else $error("async rotate wrong");
	chk_source_sel: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
		st.ctrl.async_mode ? (gate_out == adder_out) : (gate_out == st.acc))
		else $error("output source wrong");
	chk_zero_hold: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
		(accum_edge && addend == 4'h0 && !clear_edge && !wr_access) |=> $stable(st.acc))
		else $error("zero addend moved register");
	chk_clear: assert property (@(posedge pclk) disable iff (!presetn) // RQ16
		clear_edge |=> (st.acc == 4'h0 && !carry_out))
		else $error("clear failed");
	chk_dir_flip: assert property (@(posedge pclk) disable iff (!presetn) // RQ17
		(dir_flip_in && !st.dir_d) |=> subtract_eff != $past(subtract_eff)
		|| $past(wr_access))
		else $error("direction not flipped");

	// Checks on the addend, written per bit so a stuck weight shows alone
	for (genvar b = 0; b < 4; b++) begin : g_addend_chk
		// Either source of a weight must set that weight
		chk_addend_bit: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
			(st.ctrl.weight_sw[b] || gate_in[b]) |-> addend[b])
			else $error("addend bit missing");
	end

	// No switch, no gate and no carry input gives an empty addend
	chk_addend_zero: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
		(st.ctrl.weight_sw == 4'h0 && gate_in == 4'h0 && !carry_in) |-> addend == 4'h0)
		else $error("addend not empty");

	// Gate outputs follow their own register bit while the register is shown
	for (genvar g = 0; g < 4; g++) begin : g_gate_chk
		// A swapped bit order would pass a whole-word check only by luck
		chk_gate_bit: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
			!st.ctrl.async_mode |-> gate_out[g] == st.acc[g])
			else $error("gate output off its bit");
	end

	// Primary level is the plain register word in synchronous mode
	chk_primary_level: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
		!st.ctrl.async_mode |-> levels.primary == st.acc)
		else $error("primary level wrong");

	// Each offset setting gives its own fixed distance between the two levels
	chk_offset_none: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
		st.ctrl.offset_sw == 2'b00 |-> levels.shifted == levels.primary)
		else $error("offset none wrong");
	chk_offset_low: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
		st.ctrl.offset_sw == 2'b01 |-> 4'(levels.shifted - levels.primary) == 4'h2)
		else $error("offset low wrong");
	chk_offset_high: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
		st.ctrl.offset_sw == 2'b10 |-> 4'(levels.shifted - levels.primary) == 4'h4)
		else $error("offset high wrong");
	chk_offset_both: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
		st.ctrl.offset_sw == 2'b11 |-> 4'(levels.shifted - levels.primary) == 4'h8)
		else $error("offset both wrong");

	// Half-scale offset on an upper-half value must wrap into the lower half
	chk_shift_wraps: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
		(st.ctrl.offset_sw == 2'b11 && levels.primary[3]) |-> !levels.shifted[3])
		else $error("shifted level did not wrap");

	// Carry on add is set exactly when the sum passes fifteen
	chk_add_carry: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
		(accum_edge && !subtract_eff && !clear_now)
		|=> carry_out == ($past(st.acc) > 4'(4'hF - $past(addend))))
		else $error("add carry wrong");

	// Borrow on subtract is set exactly when the addend exceeds the register
	chk_sub_borrow: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
		(accum_edge && subtract_eff && !clear_now)
		|=> carry_out == ($past(addend) > $past(st.acc)))
		else $error("subtract borrow wrong");

	// Adding or taking eight only toggles the top bit
	chk_half_scale: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
		(accum_edge && addend == 4'h8 && !clear_now) |=> st.acc == ($past(st.acc) ^ 4'h8))
		else $error("half scale step wrong");

	// A rotate on a clock edge leaves no carry and moves the bits up
	chk_rotate_wins: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
		(clk_rise && rotate_edge && !clear_now)
		|=> (!carry_out && st.acc[3:1] == $past(st.acc[2:0])))
		else $error("rotate did not replace step");

	// With nothing patched into the fill the top bit comes back round
	chk_fill_recirc: assert property (@(posedge pclk) disable iff (!presetn) // RQ18
		(rotate_edge && !fill_present && !mix_in && !clear_now)
		|=> st.acc[0] == $past(st.acc[3]))
		else $error("top bit not recirculated");

	// The mix input inverts the patched fill bit when high
	chk_mix_flip: assert property (@(posedge pclk) disable iff (!presetn) // RQ19
		(rotate_edge && fill_present && !clear_now)
		|=> st.acc[0] == ($past(fill_in) ^ $past(mix_in)))
		else $error("mixed fill bit wrong");

	// The software clear pulse acts like the pin
	chk_clear_write: assert property (@(posedge pclk) disable iff (!presetn) // RQ16
		(wr_access && pwdata[`NAC_CTRL_CLEAR_BIT]) |=> (st.acc == 4'h0 && !carry_out))
		else $error("software clear failed");

	// Between edges the register holds, whatever the output source shows
	chk_hold_between: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
		(!clk_rise && !rotate_edge && !clear_now) |=> $stable(st.acc))
		else $error("register moved between edges");

	// Without a rising edge on the flip pin the direction is kept
	chk_flip_keep: assert property (@(posedge pclk) disable iff (!presetn) // RQ17
		!(dir_flip_in && !st.dir_d) |=> $stable(st.flip))
		else $error("direction flipped without edge");
endmodule

// File: dv/nac_patch.sv
// Model of the patched module that feeds count pulses into the block.
// Assumes pclk as the only clock and a bench that requests bursts.
module nac_patch (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Burst request
	input wire logic [4:0] n,
	input wire logic go,
	// Pulse output
	output logic clock_in,
	output logic busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] left;
	// One cycle high, one low per pulse, so every rise is seen alone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left <= 6'h00;
			clock_in <= 1'b0;
		end else if (go) begin
			left <= {n, 1'b0};
		end else if (left != 6'h00) begin
			left <= left - 6'h01;
			clock_in <= ~clock_in;
		end
	end
	assign busy = (left != 6'h00) | go;
endmodule

// File: dv/four_bit_accumulator_sequencer_bench.sv
// Self-checking bench for the accumulator block.
// Assumes a zero-wait APB slave and pin edges sampled on pclk.
module four_bit_accumulator_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, busy, ck;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, carry_out, rot = 0, fpres = 0, fill = 0, mix = 0, flip = 0, rin = 0;
	logic [3:0] gin = 0, gate_out;
	logic [4:0] n = 0;
	logic cin = 0;
	nac_pkg::nac_levels_t levels;
	int error_cnt = 0, total_checks = 0;
	nac_accum uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .gate_in(gin), .carry_in(cin), .clock_in(ck), .reset_in(rin),
		.dir_flip_in(flip), .rotate_req(rot), .fill_in(fill), .fill_present(fpres),
		.mix_in(mix), .gate_out(gate_out), .carry_out(carry_out), .levels(levels));
	nac_patch patch (.pclk(pclk), .presetn(presetn), .n(n), .go(go), .clock_in(ck), .busy(busy));
	// 125 MHz clock
	initial begin
		forever #4 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// Request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = pslverr ? 32'hDEAD_0000 : prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Burst of count pulses, then settle before looking
	task automatic pul(input logic [4:0] k);
		@(posedge pclk);
		n <= k;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		@(posedge pclk);
		while (busy) @(posedge pclk);
		repeat (2) @(posedge pclk);
		@(negedge pclk);
	endtask
	task automatic sta(input logic [3:0] v, input logic c);
		chk({levels.primary, gate_out, 3'h0, carry_out}, {v, v, 3'h0, c});
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Hang guard, far above the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		end_of_test;
	end
	// Count by one, wrap with carry, carry drops on the next pulse
	task automatic t_count;
		sta(4'h0, 1'b0);
		apb(1'b1, 12'h000, 32'h0000_0001);
		pul(5'h01);
		sta(4'h1, 1'b0);
		pul(5'h0F);
		sta(4'h0, 1'b1);
		pul(5'h01);
		sta(4'h1, 1'b0);
		$display("count test done");
	endtask
	// Offsets, wrap, subtract, gate and carry inputs into the addend
	task automatic t_add;
		apb(1'b1, 12'h000, 32'h0000_000D);
		pul(5'h01);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 12'h000, 32'(i << 6));
			@(negedge pclk);
			chk(levels.shifted, 32'(4'(4'hE + ((i == 3) ? 4'h8 : 4'(2 * i)))));
		end
		chk(levels.shifted, 32'h0000_0006);
		chk(levels.primary, 32'h0000_000E);
		pul(5'h01);
		sta(4'hE, 1'b0);
		apb(1'b1, 12'h000, 32'h0000_0004);
		pul(5'h01);
		sta(4'h2, 1'b1);
		apb(1'b1, 12'h000, 32'h0000_0018);
		pul(5'h01);
		chk(gate_out, 4'hA);
		pul(5'h01);
		chk(gate_out, 4'h2);
		apb(1'b1, 12'h000, 32'h0000_0010);
		gin <= 4'h1;
		pul(5'h01);
		chk(gate_out, 4'h1);
		@(posedge pclk);
		gin <= 4'h0;
		apb(1'b1, 12'h000, 32'h0000_0000);
		cin <= 1'b1;
		pul(5'h01);
		chk(gate_out, 4'h2);
		$display("add test done");
	endtask
	// Synchronous rotate with weight 4 set, so an accumulate would show
	task automatic t_rotate;
		@(posedge pclk);
		cin <= 1'b0;
		rot <= 1'b1;
		apb(1'b1, 12'h000, 32'h0000_0004);
		pul(5'h01);
		chk(gate_out, 4'h4);
		chk(levels.primary, 4'h4);
		@(posedge pclk);
		fpres <= 1'b1;
		fill <= 1'b1;
		pul(5'h01);
		chk(gate_out, 4'h9);
		@(posedge pclk);
		mix <= 1'b1;
		pul(5'h01);
		chk(gate_out, 4'h2);
		@(posedge pclk);
		rot <= 1'b0;
		mix <= 1'b0;
		$display("rotate test done");
	endtask
	// Live adder output and rotate on the shift pin alone
	task automatic t_async;
		apb(1'b1, 12'h000, 32'h0000_0023);
		@(negedge pclk);
		chk(gate_out, 4'h5);
		@(posedge pclk);
		rot <= 1'b1;
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		chk(gate_out, 4'h8);
		@(posedge pclk);
		rot <= 1'b0;
		apb(1'b1, 12'h000, 32'h0000_0000);
		@(negedge pclk);
		chk(gate_out, 4'h5);
		$display("async test done");
	endtask
	// Direction flip pin, then the clear pin
	task automatic t_flip_reset;
		apb(1'b1, 12'h000, 32'h0000_0001);
		flip <= 1'b1;
		pul(5'h01);
		chk(gate_out, 4'h4);
		@(posedge pclk);
		rin <= 1'b1;
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		sta(4'h0, 1'b0);
		$display("reset test done");
	endtask
	// Read back status and control, then an unmapped address
	task automatic t_bus;
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk(rd, 32'h0000_0600);
		apb(1'b0, 12'h000, 32'h0000_0000);
		chk(rd, 32'h0000_0001);
		apb(1'b0, 12'h008, 32'h0000_0000);
		chk(rd, 32'hDEAD_0000);
		$display("bus test done");
	endtask
	// Main sequence
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		t_count;
		t_add;
		t_rotate;
		t_async;
		t_flip_reset;
		t_bus;
		end_of_test;
	end
endmodule
